//--- hw/lrr_cmd.sv
// Purpose: Long-read and block-reassign command handling, APB slave
// Assumes: Media and spare allocator answer over simple handshakes
// Notes:   Parameter list is loaded word by word before start
// Overview of operation
// - Opcode 3Eh: correct-disable byte 1, LBA bytes 2-5, length bytes 7-8
// - Opcode 9Eh/11h: LBA bytes 2-9, length 12-13, flags in byte 14
// - Long read returns exactly one block: data, then ECC bytes in the long form only
// - Correction enabled: return block, never report a media error
// - Correction disabled: report media error when correction fails
// - Nonzero mismatched length: check condition, illegal request, bad CDB field
// - On mismatch set valid and mismatch flags, info is requested minus actual
// - Short form expects exactly the logical block size
// - Long form expects logical block size plus 18 bytes
// - Long read bypasses the data cache both ways
// - Opcode 07h, wide select picks 4-byte or 8-byte list addresses
// - Addresses arrive as a data-out parameter list
// - List: two reserved bytes, length in bytes 2-3, entries from byte 4
// - List holds at most eight addresses, enforced here
// - Each reassigned block is placed on a spare track
// - Each address that gets a spare is added to the grown defect list
// - Other data preserved; restore-disable bit decides target recovery
// - Descriptor: cylinder bytes 0-2, head byte 3, sector bytes 4-7
module lrr_cmd (
  input  logic                clk,
  input  logic                sys_rst,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [7:0]          paddr,
  input  logic [31:0]         pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  output logic                med_rd_req,
  output lrr_pkg::lrr_mreq_t  med_req,
  input  logic                med_valid,
  input  logic [7:0]          med_byte,
  input  logic                med_uncorr,
  output logic                med_ready,
  output logic                din_valid,
  output logic [7:0]          din_byte,
  input  logic                din_ready,
  output logic                rsn_req,
  output logic [63:0]         rsn_lba,
  output logic                rsn_spare_trk,
  output logic                rsn_restore,
  input  logic                rsn_ack,
  input  logic                rsn_fail,
  input  logic [63:0]         rsn_desc,
  output logic                glist_add,
  output lrr_pkg::lrr_desc_t  glist_desc,
  output logic [63:0]         glist_lba,
  output logic                cmd_done
);

  typedef enum logic [2:0] {ST_IDLE, ST_DEC, ST_RD, ST_RS_LD, ST_RS, ST_END} lrr_state_t;

  lrr_state_t  state_reg;
  logic [127:0] cdb_reg;
  logic [31:0] plist_mem [17];
  logic [4:0]  widx_reg;
  logic        rdis_reg;
  logic        done_reg;
  logic        check_reg;
  logic [3:0]  key_reg;
  logic [7:0]  asc_reg;
  logic        valid_reg;
  logic        ili_reg;
  logic [31:0] info_reg;
  logic [15:0] exp_reg;
  logic [15:0] snt_reg;
  logic        correction_disable_bit_reg;
  logic        unc_reg;
  logic        hold_v_reg;
  logic        wide_reg;
  logic [3:0]  cnt_reg;
  logic [3:0]  idx_reg;

  // Command block byte, byte 0 in the top bits
  function automatic logic [7:0] cb(input logic [127:0] v, input logic [3:0] i);
    return 8'(v >> {4'hF - i, 3'b000});
  endfunction

  // Parameter list byte, byte 0 in the top bits of word 0
  function automatic logic [7:0] pb(input logic [6:0] i);
    return 8'(plist_mem[i[6:2]] >> {2'h3 - i[1:0], 3'b000});
  endfunction

  // Address entry k of the list, 4 or 8 bytes wide
  function automatic logic [63:0] ent_lba(input logic [3:0] k, input logic w);
    logic [63:0] r;
    logic [6:0]  base;
    r = '0;
    base = w ? 7'(4 + 8 * k) : 7'(4 + 4 * k);
    for (int j = 0; j < 8; j++) begin
      if (w || j < 4) begin
        r = {r[55:0], pb(7'(base + 7'(j)))};
      end
    end
    return r;
  endfunction

  // Command decode
  wire [7:0]  op      = cb(cdb_reg, 4'd0);
  wire [7:0]  b1      = cb(cdb_reg, 4'd1);
  wire [7:0]  b14     = cb(cdb_reg, 4'd14);
  wire        is_rl10 = op == lrr_pkg::OP_RL10;
  wire        is_rl16 = op == lrr_pkg::OP_RL16 && b1[4:0] == lrr_pkg::SA_RL16;
  wire        rl_any  = is_rl10 | is_rl16;
  wire        is_rsn  = op == lrr_pkg::OP_RSN;
  wire [15:0] xfer_10 = {cb(cdb_reg, 4'd7), cb(cdb_reg, 4'd8)};
  wire [15:0] xfer_16 = {cb(cdb_reg, 4'd12), cb(cdb_reg, 4'd13)};
  wire [15:0] rl_xfer = is_rl10 ? xfer_10 : xfer_16;
  wire [15:0] exp_16  = 16'(lrr_pkg::BLK_SIZE + lrr_pkg::ECC_EXTRA);
  wire [15:0] rl_exp  = is_rl10 ? lrr_pkg::BLK_SIZE : exp_16;
  wire        rl_correction_disable_bit = is_rl10 ? b1[1] : b14[0];
  wire        rl_pblk = is_rl16 & b14[1];
  wire [31:0] lba_lo  = {cb(cdb_reg, 4'd2), cb(cdb_reg, 4'd3),
                         cb(cdb_reg, 4'd4), cb(cdb_reg, 4'd5)};
  wire [63:0] lba_16  = {lba_lo, cb(cdb_reg, 4'd6), cb(cdb_reg, 4'd7),
                         cb(cdb_reg, 4'd8), cb(cdb_reg, 4'd9)};
  wire [63:0] rl_lba  = is_rl10 ? {32'h0000_0000, lba_lo} : lba_16;
  wire        len_bad = rl_xfer != 16'h0000 && rl_xfer != rl_exp;
  wire [16:0] rl_diff = 17'({1'b0, rl_xfer} - {1'b0, rl_exp});
  wire [31:0] info_w  = {{15{rl_diff[16]}}, rl_diff};

  // Reassign list checks
  wire [15:0] rs_len   = {pb(7'd2), pb(7'd3)};
  wire        rs_wide  = b1[1];
  wire [15:0] rs_n     = rs_wide ? (rs_len >> 3) : (rs_len >> 2);
  wire        rs_frag  = rs_wide ? |rs_len[2:0] : |rs_len[1:0];
  wire        rs_short = {10'h000, widx_reg, 2'b00} < 17'({1'b0, rs_len} + 17'd4);
  wire        rs_bad   = rs_frag | rs_n > lrr_pkg::RS_MAX | rs_short;

  // APB decode
  wire        idle    = state_reg == ST_IDLE;
  wire        acc     = psel & penable;
  wire        wr      = acc & pwrite & map_ok; // Unmapped or misaligned writes are dropped
  wire        setup   = psel & ~penable;
  wire        map_ok  = paddr <= lrr_pkg::OFF_INFO && paddr[1:0] == 2'b00;
  wire        wr_cdb  = wr & idle & paddr < lrr_pkg::OFF_CTRL;
  wire        wr_ctrl = wr & paddr == lrr_pkg::OFF_CTRL;
  wire        wr_parm = wr & idle & paddr == lrr_pkg::OFF_PARAM & widx_reg < lrr_pkg::PL_WORDS;
  wire        start_w = wr_ctrl & idle & pwdata[lrr_pkg::CTL_START];
  wire [31:0] stat_w  = {28'h0000000, unc_reg, check_reg, done_reg, ~idle};
  wire [31:0] sense_w = {valid_reg, ili_reg, 18'h00000, key_reg, asc_reg};
  wire [31:0] rd_mux  =
      paddr == lrr_pkg::OFF_CDB0  ? cdb_reg[127:96] :
      paddr == lrr_pkg::OFF_CDB1  ? cdb_reg[95:64]  :
      paddr == lrr_pkg::OFF_CDB2  ? cdb_reg[63:32]  :
      paddr == lrr_pkg::OFF_CDB3  ? cdb_reg[31:0]   :
      paddr == lrr_pkg::OFF_CTRL  ? {30'h00000000, rdis_reg, 1'b0} :
      paddr == lrr_pkg::OFF_PARAM ? {27'h0000000, widx_reg} :
      paddr == lrr_pkg::OFF_STAT  ? stat_w :
      paddr == lrr_pkg::OFF_SENSE ? sense_w :
      paddr == lrr_pkg::OFF_INFO  ? info_reg : lrr_pkg::RST_WORD;
  assign pready  = acc;
  assign pslverr = acc & ~map_ok;

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= lrr_pkg::RST_WORD;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  // Command block, control and parameter list storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cdb_reg  <= '0;
      rdis_reg <= 1'b0;
      widx_reg <= 5'h00;
    end else begin
      if (wr_cdb) begin
        cdb_reg[{~paddr[3:2], 5'b00000} +: 32] <= pwdata;
      end
      if (wr_ctrl) begin
        rdis_reg <= pwdata[lrr_pkg::CTL_RDIS];
      end
      if (state_reg == ST_END) begin
        widx_reg <= 5'h00;
      end else if (wr_parm) begin
        widx_reg <= widx_reg + 5'h01;
      end
    end
  end

  // List memory, no reset needed
  always_ff @(posedge clk) begin
    if (wr_parm) begin
      plist_mem[widx_reg] <= pwdata;
    end
  end

  // Media streaming handshakes
  wire st_rd = state_reg == ST_RD;
  assign med_ready  = st_rd & ~hold_v_reg & snt_reg < exp_reg;
  wire   take       = med_valid & med_ready;
  wire   give       = hold_v_reg & din_ready;
  wire   rd_last    = give & snt_reg == 16'(exp_reg - 16'h0001);
  assign din_valid  = hold_v_reg;
  assign med_rd_req = st_rd;
  assign rsn_req    = state_reg == ST_RS;
  assign rsn_spare_trk = rsn_req;
  assign rsn_restore   = ~rdis_reg;
  assign cmd_done   = state_reg == ST_END;

  // Byte holding stage toward the initiator
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_v_reg <= 1'b0;
      din_byte   <= 8'h00;
      snt_reg    <= 16'h0000;
      unc_reg    <= 1'b0;
    end else begin
      if (take) begin
        hold_v_reg <= 1'b1;
        din_byte   <= med_byte;
        unc_reg    <= unc_reg | med_uncorr;
      end else if (give) begin
        hold_v_reg <= 1'b0;
      end
      if (give) begin
        snt_reg <= snt_reg + 16'h0001;
      end else if (state_reg == ST_DEC) begin
        snt_reg <= 16'h0000;
        unc_reg <= 1'b0;
      end
    end
  end

  // Defect list entry from the allocator's physical descriptor
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      glist_add  <= 1'b0;
      glist_desc <= '0;
      glist_lba  <= 64'h0000_0000_0000_0000;
    end else begin
      glist_add <= rsn_req & rsn_ack & ~rsn_fail;
      if (rsn_req & rsn_ack) begin
        glist_desc.cyl  <= rsn_desc[63:40];
        glist_desc.head <= rsn_desc[39:32];
        glist_desc.sect <= rsn_desc[31:0];
        glist_lba       <= rsn_lba;
      end
    end
  end

  // Sequencer and sense reporting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      done_reg  <= 1'b0;
      check_reg <= 1'b0;
      key_reg   <= 4'h0;
      asc_reg   <= 8'h00;
      valid_reg <= 1'b0;
      ili_reg   <= 1'b0;
      info_reg  <= lrr_pkg::RST_WORD;
      exp_reg   <= 16'h0000;
      correction_disable_bit_reg <= 1'b0;
      wide_reg  <= 1'b0;
      cnt_reg   <= 4'h0;
      idx_reg   <= 4'h0;
      med_req   <= '0;
      rsn_lba   <= 64'h0000_0000_0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_w) begin
            state_reg <= ST_DEC;
            done_reg  <= 1'b0;
            check_reg <= 1'b0;
            key_reg   <= 4'h0;
            asc_reg   <= 8'h00;
            valid_reg <= 1'b0;
            ili_reg   <= 1'b0;
            info_reg  <= lrr_pkg::RST_WORD;
          end
        end
        ST_DEC: begin
          state_reg <= ST_END;
          exp_reg   <= rl_exp;
          correction_disable_bit_reg <= rl_correction_disable_bit;
          wide_reg  <= rs_wide;
          cnt_reg   <= rs_n[3:0];
          idx_reg   <= 4'h0;
          if (rl_any && len_bad) begin
            check_reg <= 1'b1;
            key_reg   <= lrr_pkg::KEY_ILL;
            asc_reg   <= lrr_pkg::ASC_CDB;
            valid_reg <= 1'b1;
            ili_reg   <= 1'b1;
            info_reg  <= info_w;
          end else if (rl_any) begin
            state_reg   <= ST_RD;
            med_req.lba <= rl_lba;
            med_req.pblk <= rl_pblk;
            med_req.bypass <= 1'b1;
          end else if (is_rsn && rs_bad) begin
            check_reg <= 1'b1;
            key_reg   <= lrr_pkg::KEY_ILL;
            asc_reg   <= lrr_pkg::ASC_PARM;
          end else if (is_rsn && rs_n != 16'h0000) begin
            state_reg <= ST_RS_LD;
          end else if (!is_rsn) begin
            check_reg <= 1'b1;
            key_reg   <= lrr_pkg::KEY_ILL;
            asc_reg   <= lrr_pkg::ASC_CDB;
          end
        end
        ST_RD: begin
          if (rd_last) begin
            state_reg      <= ST_END;
            med_req.bypass <= 1'b0;
            if (correction_disable_bit_reg && (unc_reg || (take && med_uncorr))) begin
              check_reg <= 1'b1;
              key_reg   <= lrr_pkg::KEY_MED;
              asc_reg   <= lrr_pkg::ASC_UNREC;
            end
          end
        end
        ST_RS_LD: begin
          rsn_lba   <= ent_lba(idx_reg, wide_reg);
          state_reg <= ST_RS;
        end
        ST_RS: begin
          if (rsn_ack && rsn_fail) begin
            state_reg <= ST_END;
            check_reg <= 1'b1;
            key_reg   <= lrr_pkg::KEY_HW;
            asc_reg   <= lrr_pkg::ASC_NOSPARE;
          end else if (rsn_ack) begin
            idx_reg   <= idx_reg + 4'h1;
            state_reg <= (idx_reg + 4'h1 == cnt_reg) ? ST_END : ST_RS_LD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          done_reg  <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb_main @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_LEN_SENSE: assert property ((state_reg == ST_DEC && rl_any && len_bad) |=>
      check_reg && key_reg == lrr_pkg::KEY_ILL && asc_reg == lrr_pkg::ASC_CDB)
    else $error("length mismatch sense wrong");
  AST_LEN_INFO: assert property ((state_reg == ST_DEC && rl_any && len_bad) |=>
      valid_reg && ili_reg && info_reg == $past(info_w))
    else $error("length mismatch info wrong");
  AST_EXP_LEN: assert property ((state_reg == ST_DEC && is_rl16) |=>
      exp_reg == 16'h0212)
    else $error("long form length wrong");
  AST_ONE_BLK: assert property (st_rd |-> snt_reg <= exp_reg)
    else $error("more than one block sent");
  AST_RD_END: assert property (rd_last |=> cmd_done)
    else $error("read did not end after last byte");
  AST_BYPASS: assert property (med_rd_req |-> med_req.bypass)
    else $error("long read not bypassing cache");
  AST_NO_MEDERR: assert property (($past(st_rd) && cmd_done && !correction_disable_bit_reg) |-> !check_reg)
    else $error("media error with correction on");
  AST_MEDERR: assert property (($past(st_rd) && cmd_done && correction_disable_bit_reg && unc_reg) |->
      check_reg && key_reg == lrr_pkg::KEY_MED)
    else $error("media error not reported");
  AST_SPARE: assert property (rsn_req |-> rsn_spare_trk)
    else $error("spare track not requested");
  AST_GLIST: assert property ((rsn_req && rsn_ack && !rsn_fail) |=>
      glist_add && glist_lba == $past(rsn_lba))
    else $error("defect list entry missing");
  AST_DESC: assert property (glist_add |-> glist_desc == $past(rsn_desc))
    else $error("descriptor fields wrong");
  AST_SHORT_LBA: assert property ((rsn_req && !wide_reg) |-> rsn_lba[63:32] == 32'h0)
    else $error("short address has high bytes");
  AST_RS_MAX: assert property (rsn_req |-> idx_reg < 4'h8)
    else $error("too many reassign entries");

  COV_RD_GOOD: cover property ($past(st_rd) && cmd_done && !check_reg);
  COV_LEN_BAD: cover property (cmd_done && ili_reg);
  COV_RSN_TWO: cover property (glist_add ##[1:20] glist_add);
endmodule

//--- include/lrr_pkg.sv
// Purpose: Shared constants and carriers for the long-read and reassign block
// Assumes: APB register access, 32-bit data, one clock
// Notes:   Multi-byte fields are carried most significant byte first
package lrr_pkg;
  // Operation codes
  localparam logic [7:0]  OP_RL10     = 8'h3E;
  localparam logic [7:0]  OP_RL16     = 8'h9E;
  localparam logic [7:0]  OP_RSN      = 8'h07;
  localparam logic [4:0]  SA_RL16     = 5'h11;
  // Transfer sizes
  localparam logic [15:0] BLK_SIZE    = 16'h0200;
  localparam logic [15:0] ECC_EXTRA   = 16'h0012;
  localparam logic [15:0] RS_MAX      = 16'h0008;
  localparam logic [4:0]  PL_WORDS    = 5'h11;
  // Sense keys and codes
  localparam logic [3:0]  KEY_MED     = 4'h3;
  localparam logic [3:0]  KEY_HW      = 4'h4;
  localparam logic [3:0]  KEY_ILL     = 4'h5;
  localparam logic [7:0]  ASC_UNREC   = 8'h11;
  localparam logic [7:0]  ASC_CDB     = 8'h24;
  localparam logic [7:0]  ASC_PARM    = 8'h26;
  localparam logic [7:0]  ASC_NOSPARE = 8'h32;
  // Register offsets
  localparam logic [7:0]  OFF_CDB0    = 8'h00;
  localparam logic [7:0]  OFF_CDB1    = 8'h04;
  localparam logic [7:0]  OFF_CDB2    = 8'h08;
  localparam logic [7:0]  OFF_CDB3    = 8'h0C;
  localparam logic [7:0]  OFF_CTRL    = 8'h10;
  localparam logic [7:0]  OFF_PARAM   = 8'h14;
  localparam logic [7:0]  OFF_STAT    = 8'h18;
  localparam logic [7:0]  OFF_SENSE   = 8'h1C;
  localparam logic [7:0]  OFF_INFO    = 8'h20;
  // Field positions and reset value
  localparam int          CTL_START   = 0;
  localparam int          CTL_RDIS    = 1;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  // Physical-sector defect descriptor
  typedef struct packed {
    logic [23:0] cyl;
    logic [7:0]  head;
    logic [31:0] sect;
  } lrr_desc_t;
  // Media read request
  typedef struct packed {
    logic [63:0] lba;
    logic        pblk;
    logic        bypass;
  } lrr_mreq_t;
endpackage

//--- sim/lrr_media_model.sv
// Purpose: Media reader and spare allocator on the far side of the command block
// Assumes: One clock; bytes of a read are numbered from zero
// Notes:   Lines not qualified show the inverse of their next value; rsn_fail follows rsn_ack while no_spare is set
module lrr_media_model (
  input  wire logic  clk,
  input  wire logic  med_rd_req,
  input  wire logic  med_ready,
  input  wire logic  rsn_req,
  input  wire logic  bad_blk,
  input  wire logic  no_spare,
  output logic       med_valid,
  output logic [7:0] med_byte,
  output logic       med_uncorr,
  output logic       rsn_ack,
  output logic       rsn_fail,
  output logic [63:0] rsn_desc
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] DESC = 64'h0001_2303_0000_0456;
  logic [7:0] cnt_reg;
  logic [1:0] wait_reg;
  initial begin
    med_valid = 1'b0;
    rsn_ack   = 1'b0;
    cnt_reg   = 8'h00;
    wait_reg  = 2'h0;
  end
  // One byte offered and held until taken, then a gap cycle
  always @(posedge clk) begin
    if (!med_rd_req) begin
      med_valid <= 1'b0;
      cnt_reg   <= 8'h00;
    end else if (med_valid && med_ready) begin
      med_valid <= 1'b0;
      cnt_reg   <= cnt_reg + 8'h01;
    end else begin
      med_valid <= 1'b1;
    end
  end
  // Spare found, or refused under no_spare, a few cycles after each request
  always @(posedge clk) begin
    rsn_ack  <= rsn_req && !rsn_ack && wait_reg == 2'h3;
    wait_reg <= (rsn_req && !rsn_ack) ? wait_reg + 2'h1 : 2'h0;
  end
  // Qualified values only while offered
  assign med_byte   = med_valid ? cnt_reg : ~cnt_reg;
  assign med_uncorr = med_valid ? bad_blk : ~bad_blk;
  assign rsn_fail   = rsn_ack & no_spare;
  assign rsn_desc   = rsn_ack ? DESC : ~DESC;
endmodule

//--- sim/lrr_cmd_test.sv
// Purpose: Self-checking bench for the long-read and reassign block
// Assumes: Zero-wait APB slave, media model on the far side
// Notes:   Status and sense are read back after every command
module lrr_cmd_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00, med_byte, din_byte;
  logic [31:0]        pwdata = 32'h0, prdata, rdat;
  logic               pready, pslverr, rerr, med_rd_req, med_valid, med_uncorr, med_ready;
  logic               din_valid, din_ready = 1'b0, rsn_req, rsn_spare_trk, rsn_restore;
  logic               rsn_ack, rsn_fail, glist_add, cmd_done, xpb;
  logic               bad_blk = 1'b0, no_spare = 1'b0, restore_disable_bit = 1'b0;
  logic [63:0]        rsn_lba, rsn_desc, glist_lba, xlba;
  logic [63:0]        lq[$];
  lrr_pkg::lrr_mreq_t med_req;
  lrr_pkg::lrr_desc_t glist_desc;
  int                 err_total = 0, n_compared = 0, nbytes, cyc = 0;

  lrr_cmd dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .med_rd_req, .med_req, .med_valid, .med_byte, .med_uncorr, .med_ready,
    .din_valid, .din_byte, .din_ready, .rsn_req, .rsn_lba, .rsn_spare_trk, .rsn_restore,
    .rsn_ack, .rsn_fail, .rsn_desc, .glist_add, .glist_desc, .glist_lba, .cmd_done);
  lrr_media_model far (.clk, .med_rd_req, .med_ready, .rsn_req, .bad_blk, .no_spare,
    .med_valid, .med_byte, .med_uncorr, .rsn_ack, .rsn_fail, .rsn_desc);

  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cdb(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2,
                     input logic [31:0] w3);
    apb(1'b1, lrr_pkg::OFF_CDB0, w0);
    apb(1'b1, lrr_pkg::OFF_CDB1, w1);
    apb(1'b1, lrr_pkg::OFF_CDB2, w2);
    apb(1'b1, lrr_pkg::OFF_CDB3, w3);
  endtask

  // Start, then serve data-in with stalls and log reassign traffic
  task automatic run(input int exp_n);
    nbytes = 0;
    lq = {};
    apb(1'b1, lrr_pkg::OFF_CTRL, {30'h0, restore_disable_bit, 1'b1});
    while (cmd_done !== 1'b1) begin
      @(posedge clk);
      din_ready <= ~din_ready;
      if ((din_valid & din_ready) === 1'b1) begin
        chk("data byte", din_byte, nbytes[7:0]);
        nbytes++;
      end
      if (med_rd_req === 1'b1) begin
        chk("media lba", med_req.lba, xlba);
        chk("media flags", {med_req.pblk, med_req.bypass}, {xpb, 1'b1});
      end
      if ((rsn_req & rsn_ack) === 1'b1) begin
        lq.push_back(rsn_lba);
        chk("spare track", rsn_spare_trk, 1'b1);
        chk("restore", rsn_restore, !restore_disable_bit);
      end
      if (glist_add === 1'b1) begin
        chk("glist lba", glist_lba, lq[$]);
        chk("glist desc", glist_desc, {24'h000123, 8'h03, 32'h456});
      end
    end
    if (exp_n >= 0)
      chk("byte count", 64'(nbytes), 64'(exp_n));
  endtask

  task automatic verdict(input string nm, input logic [3:0] key, input logic [7:0] asc,
                         input logic [31:0] info);
    apb(1'b0, lrr_pkg::OFF_STAT, 32'h0);
    chk("status", rdat[2:1], {key != 4'h0, 1'b1});
    apb(1'b0, lrr_pkg::OFF_SENSE, 32'h0);
    if (key != 4'h0)
      chk("sense", rdat[11:0], {key, asc});
    if (info != 32'h0) begin
      chk("sense flags", rdat[31:30], 2'b11);
      apb(1'b0, lrr_pkg::OFF_INFO, 32'h0);
      chk("info", rdat, info);
    end
    $display("test %s done", nm);
  endtask

  task automatic t_regs;
    apb(1'b0, lrr_pkg::OFF_STAT, 32'h0);
    chk("status reset", rdat, lrr_pkg::RST_WORD);
    apb(1'b0, lrr_pkg::OFF_INFO, 32'h0);
    chk("info reset", rdat, lrr_pkg::RST_WORD);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped read", {rerr, rdat}, {1'b1, 32'h0});
    apb(1'b1, 8'h02, 32'hFFFF_FFFF);
    chk("misaligned write", rerr, 1'b1);
    apb(1'b0, lrr_pkg::OFF_CDB0, 32'h0);
    chk("dropped write", {rerr, rdat}, 33'h0);
    $display("test registers done");
  endtask

  task automatic t_read10(input logic correction_disable_bit, input logic [15:0] len, input int n);
    xlba = 64'h89AB_CDEF;
    xpb = 1'b0;
    cdb({8'h3E, 6'h0, correction_disable_bit, 1'b0, 16'h89AB}, {16'hCDEF, 8'h00, len[15:8]},
        {len[7:0], 24'h0}, 32'h0);
    run(n);
  endtask

  task automatic t_read16(input logic correction_disable_bit, input logic [15:0] len, input int n);
    xlba = 64'h0123_4567_89AB_CDEF;
    xpb = 1'b1;
    cdb(32'h9E11_0123, 32'h4567_89AB, 32'hCDEF_0000,
        {len, 7'h01, correction_disable_bit, 8'h00});
    run(n);
  endtask

  task automatic t_rsn(input logic wide_address_select, input int n, input int exp_cnt);
    cdb({8'h07, 6'h0, wide_address_select, 17'h0}, 32'h0, 32'h0, 32'h0);
    apb(1'b1, lrr_pkg::OFF_PARAM, 32'(n * (wide_address_select ? 8 : 4)));
    for (int i = 0; i < n; i++) begin
      if (wide_address_select)
        apb(1'b1, lrr_pkg::OFF_PARAM, 32'hA0 + 32'(i));
      apb(1'b1, lrr_pkg::OFF_PARAM, 32'h5000_0000 + 32'(i));
    end
    run(-1);
    chk("reassign count", 64'(lq.size()), 64'(exp_cnt));
    foreach (lq[i])
      chk("reassign lba", lq[i], {wide_address_select ? 32'hA0 + 32'(i) : 32'h0,
                                  32'h5000_0000 + 32'(i)});
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    bad_blk <= 1'b1;
    t_read10(1'b0, 16'h0000, 512);
    verdict("read10 corrected", 4'h0, 8'h00, 32'h0);
    bad_blk <= 1'b0;
    t_read16(1'b1, 16'h0212, 530);
    verdict("read16 clean", 4'h0, 8'h00, 32'h0);
    bad_blk <= 1'b1;
    t_read16(1'b1, 16'h0212, -1);
    verdict("read16 uncorrected", lrr_pkg::KEY_MED, lrr_pkg::ASC_UNREC, 32'h0);
    t_read10(1'b0, 16'h0201, 0);
    verdict("read10 long", lrr_pkg::KEY_ILL, lrr_pkg::ASC_CDB, 32'h1);
    t_read16(1'b0, 16'h0200, 0);
    verdict("read16 short", lrr_pkg::KEY_ILL, lrr_pkg::ASC_CDB, 32'hFFFF_FFEE);
    cdb(32'h9E10_0000, 32'h0, 32'h0, 32'h0);
    run(0);
    verdict("read16 bad action", lrr_pkg::KEY_ILL, lrr_pkg::ASC_CDB, 32'h0);
    t_rsn(1'b0, 2, 2);
    verdict("reassign narrow", 4'h0, 8'h00, 32'h0);
    restore_disable_bit <= 1'b1;
    t_rsn(1'b1, 2, 2);
    verdict("reassign wide", 4'h0, 8'h00, 32'h0);
    t_rsn(1'b0, 0, 0);
    verdict("reassign empty", 4'h0, 8'h00, 32'h0);
    t_rsn(1'b0, 9, 0);
    verdict("reassign too many", lrr_pkg::KEY_ILL, lrr_pkg::ASC_PARM, 32'h0);
    no_spare <= 1'b1;
    t_rsn(1'b0, 1, 1);
    verdict("reassign no spare", lrr_pkg::KEY_HW, lrr_pkg::ASC_NOSPARE, 32'h0);
    finish_test;
  end
endmodule
